//--- rtl/brf_bank.sv
// One register bank: four data words, two address words, frame base.
// Assumes the caller only asks for byte lanes on data zero and one.
`default_nettype none

module brf_bank (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire brf_pkg::brf_bank_wr_t wr_i,
    output brf_pkg::brf_bank_t       regs_o
);

    brf_pkg::brf_bank_t regs_ff;
    brf_pkg::brf_bank_t nxt_regs;

    // Byte writes keep the other half untouched
    always_comb begin
        nxt_regs = regs_ff;
        if (wr_i.en) begin
            unique case (wr_i.lane)
                brf_pkg::LANE_WORD: nxt_regs.word[wr_i.sel]       = wr_i.data;
                brf_pkg::LANE_LOW:  nxt_regs.word[wr_i.sel][7:0]  = wr_i.data[7:0];
                brf_pkg::LANE_HIGH: nxt_regs.word[wr_i.sel][15:8] = wr_i.data[7:0];
                default:            nxt_regs = regs_ff;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            regs_ff <= {brf_pkg::BANK_WORDS{brf_pkg::RST_WORD}};
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign regs_o = regs_ff;

endmodule : brf_bank

`default_nettype wire

//--- rtl/brf_flag_calc.sv
// Result flags and interrupt acceptance, purely combinational.
// Assumes the ALU result is valid whenever the core samples these outputs.
`default_nettype none

module brf_flag_calc (
    input  wire logic [15:0] alu_res_i,
    input  wire logic        alu_byte_i,
    input  wire logic        irq_req_i,
    input  wire logic [2:0]  irq_prio_i,
    input  wire logic [2:0]  ipl_i,
    input  wire logic        irq_en_i,
    output logic             zero_o,
    output logic             sign_o,
    output logic             accept_o
);

    // Byte operations only look at the low lane
    always_comb begin
        if (alu_byte_i) begin
            zero_o = (alu_res_i[7:0] == 8'h00);
            sign_o = alu_res_i[7];
        end else begin
            zero_o = (alu_res_i == 16'h0000);
            sign_o = alu_res_i[15];
        end
    end

    // Equal priority is refused, the level must be beaten
    assign accept_o = irq_req_i & irq_en_i & (irq_prio_i > ipl_i);

endmodule : brf_flag_calc

`default_nettype wire

//--- rtl/brf_pkg.sv
// Constants, register indices and carrier types of the banked register file.
// Assumes one clock domain; every user names items as brf_pkg::name.
// Contract
// - Thirteen registers; data, address and frame base exist as two banks.
// - Bank-select flag clear picks bank zero, set picks bank one.
// - Data registers are 16 bits; first two also split into byte halves.
// - Data two:zero and data three:one form 32-bit data operands.
// - Address registers are 16 bits; one:zero form a 32-bit address.
// - Frame base register is 16 bits wide.
// - Static base register is 16 bits wide.
// - Vector table base register is 20 bits wide.
// - Program counter is 20 bits wide.
// - Stack pointer is 16 bits; select clear picks irq, set picks user.
// - Stack select clears on interrupt acknowledge or software vector 0 to 31.
// - Flag word is 11 bits and shows the processor state.
// - Carry flag captures the carry, borrow or shifted-out bit of each ALU op.
// - Zero flag set when the result is zero, else cleared.
// - Sign flag set when the result is negative, else cleared.
// - Overflow flag set when the operation overflows, else cleared.
// - Interrupt enable clear blocks maskable interrupts, set permits them.
// - Interrupt enable clears whenever an interrupt is acknowledged.
// - Reserved flag bit reads undefined; software writes it as zero.
`default_nettype none

package brf_pkg;

    localparam int unsigned ADDR_W     = 5;
    localparam int unsigned DATA_W     = 20;
    localparam int unsigned FLAG_W     = 11;
    localparam int unsigned BANK_WORDS = 7;
    localparam int unsigned NUM_BANKS  = 2;

    // Register indices on the software port
    localparam logic [4:0] IDX_DATA_REG_ZERO  = 5'h00;
    localparam logic [4:0] IDX_DATA_REG_ONE   = 5'h01;
    localparam logic [4:0] IDX_FRAME_BASE     = 5'h06;
    localparam logic [4:0] IDX_VECTOR_BASE    = 5'h07;
    localparam logic [4:0] IDX_PROGRAM_CNT    = 5'h08;
    localparam logic [4:0] IDX_STACK_POINTER  = 5'h09;
    localparam logic [4:0] IDX_USER_STACK     = 5'h0a;
    localparam logic [4:0] IDX_IRQ_STACK      = 5'h0b;
    localparam logic [4:0] IDX_STATIC_BASE    = 5'h0c;
    localparam logic [4:0] IDX_PROC_FLAGS     = 5'h0d;
    localparam logic [4:0] IDX_DATA_ZERO_LOW  = 5'h0e;
    localparam logic [4:0] IDX_DATA_ZERO_HIGH = 5'h0f;
    localparam logic [4:0] IDX_DATA_ONE_LOW   = 5'h10;
    localparam logic [4:0] IDX_DATA_ONE_HIGH  = 5'h11;

    // Highest software vector that moves the core onto the irq stack
    localparam logic [5:0] SWI_LAST_STACK_VEC = 6'h1f;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [19:0] RST_WIDE = 20'h00000;

    // Flag word, carry at bit 0 up to priority level at bits 10:8
    typedef struct packed {
        logic [2:0] processor_priority_level;
        logic       stack_sel;
        logic       irq_en;
        logic       ovf;
        logic       bank_sel;
        logic       sign;
        logic       zero;
        logic       debug;
        logic       carry;
    } brf_flags_t;

    localparam brf_flags_t RST_FLAGS = brf_flags_t'(11'h000);

    typedef enum logic [2:0] {
        LANE_WORD = 3'h1,
        LANE_LOW  = 3'h2,
        LANE_HIGH = 3'h4
    } brf_lane_t;

    // One bank: data zero..three, address zero, one, frame base
    typedef struct packed {
        logic [BANK_WORDS-1:0][15:0] word;
    } brf_bank_t;

    typedef struct packed {
        logic       en;
        logic [2:0] sel;
        brf_lane_t  lane;
        logic [15:0] data;
    } brf_bank_wr_t;

endpackage : brf_pkg

`default_nettype wire

//--- rtl/brf_regfile.sv
// Banked programmer-visible register file and flag word of the core.
// Assumes strobes are one cycle, never both at once; read data follow a cycle later.
`default_nettype none

module brf_regfile (
    input  wire logic               CLK_I,
    input  wire logic               RST_B_I,
    input  wire logic [4:0]         REG_ADDR_I,
    input  wire logic [19:0]        REG_WDATA_I,
    input  wire logic               REG_WR_I,
    input  wire logic               REG_RD_I,
    output logic [19:0]             REG_RDATA_O,
    input  wire logic               ALU_UPD_I,
    input  wire logic               ALU_BYTE_I,
    input  wire logic [15:0]        ALU_RES_I,
    input  wire logic               ALU_CARRY_I,
    input  wire logic               ALU_OVF_I,
    input  wire logic               IRQ_REQ_I,
    input  wire logic [2:0]         IRQ_PRIO_I,
    output logic                    IRQ_ACCEPT_O,
    input  wire logic               IRQ_ACK_I,
    input  wire logic               SWI_I,
    input  wire logic [5:0]         SWI_VEC_I,
    output logic [31:0]             LONG_DATA_PAIR_LOW_O,
    output logic [31:0]             LONG_DATA_PAIR_HIGH_O,
    output logic [31:0]             LONG_ADDRESS_PAIR_O,
    output logic [15:0]             FRAME_BASE_O,
    output logic [15:0]             STATIC_BASE_O,
    output logic [19:0]             VECTOR_TABLE_BASE_O,
    output logic [19:0]             PROGRAM_COUNTER_O,
    output logic [15:0]             STACK_POINTER_O,
    output brf_pkg::brf_flags_t     PROCESSOR_FLAGS_O
);

    typedef struct packed {
        logic [19:0]         vector_table_base;
        logic [19:0]         program_counter;
        logic [15:0]         user_stack_pointer;
        logic [15:0]         irq_stack_pointer;
        logic [15:0]         static_base;
        brf_pkg::brf_flags_t flags;
        logic [19:0]         rdata;
    } brf_core_state_t;

    brf_core_state_t       state_ff;
    brf_core_state_t       nxt_state;
    brf_pkg::brf_bank_t    bank_regs [brf_pkg::NUM_BANKS];
    brf_pkg::brf_bank_t    cur_bank;
    brf_pkg::brf_bank_wr_t bank_wr;
    logic                  calc_zero;
    logic                  calc_sign;
    logic                  swi_to_irq_stack;
    logic [19:0]           rd_mux;

    // Result flags and acceptance test
    brf_flag_calc u_flag_calc (
        .alu_res_i  (ALU_RES_I),
        .alu_byte_i (ALU_BYTE_I),
        .irq_req_i  (IRQ_REQ_I),
        .irq_prio_i (IRQ_PRIO_I),
        .ipl_i      (state_ff.flags.processor_priority_level),
        .irq_en_i   (state_ff.flags.irq_en),
        .zero_o     (calc_zero),
        .sign_o     (calc_sign),
        .accept_o   (IRQ_ACCEPT_O)
    );

    // Software writes to bank-resident words, byte indices folded onto data zero/one
    always_comb begin
        bank_wr.en   = 1'b0;
        bank_wr.sel  = REG_ADDR_I[2:0];
        bank_wr.lane = brf_pkg::LANE_WORD;
        bank_wr.data = REG_WDATA_I[15:0];
        if (REG_WR_I) begin
            if (REG_ADDR_I < brf_pkg::IDX_VECTOR_BASE) begin
                bank_wr.en = 1'b1;
            end else if (REG_ADDR_I == brf_pkg::IDX_DATA_ZERO_LOW) begin
                bank_wr.en   = 1'b1;
                bank_wr.sel  = brf_pkg::IDX_DATA_REG_ZERO[2:0];
                bank_wr.lane = brf_pkg::LANE_LOW;
            end else if (REG_ADDR_I == brf_pkg::IDX_DATA_ZERO_HIGH) begin
                bank_wr.en   = 1'b1;
                bank_wr.sel  = brf_pkg::IDX_DATA_REG_ZERO[2:0];
                bank_wr.lane = brf_pkg::LANE_HIGH;
            end else if (REG_ADDR_I == brf_pkg::IDX_DATA_ONE_LOW) begin
                bank_wr.en   = 1'b1;
                bank_wr.sel  = brf_pkg::IDX_DATA_REG_ONE[2:0];
                bank_wr.lane = brf_pkg::LANE_LOW;
            end else if (REG_ADDR_I == brf_pkg::IDX_DATA_ONE_HIGH) begin
                bank_wr.en   = 1'b1;
                bank_wr.sel  = brf_pkg::IDX_DATA_REG_ONE[2:0];
                bank_wr.lane = brf_pkg::LANE_HIGH;
            end
        end
    end

    // Two copies; only the bank named by the flag word takes the write
    for (genvar b = 0; b < brf_pkg::NUM_BANKS; b++) begin : g_bank
        brf_pkg::brf_bank_wr_t this_wr;
        always_comb begin
            this_wr    = bank_wr;
            this_wr.en = bank_wr.en & (state_ff.flags.bank_sel == 1'(b));
        end
        brf_bank u_bank (
            .clk_i   (CLK_I),
            .rst_b_i (RST_B_I),
            .wr_i    (this_wr),
            .regs_o  (bank_regs[b])
        );
    end

    assign cur_bank = state_ff.flags.bank_sel ? bank_regs[1] : bank_regs[0];

    // Only software vectors 0..31 switch onto the irq stack
    assign swi_to_irq_stack = SWI_I & (SWI_VEC_I <= brf_pkg::SWI_LAST_STACK_VEC);

    // Read selection; the reserved bit above the flag word reads as zero
    always_comb begin
        rd_mux = 20'h00000;
        if (REG_ADDR_I < brf_pkg::IDX_VECTOR_BASE) begin
            rd_mux = {4'h0, cur_bank.word[REG_ADDR_I[2:0]]};
        end else begin
            unique case (REG_ADDR_I)
                brf_pkg::IDX_VECTOR_BASE:    rd_mux = state_ff.vector_table_base;
                brf_pkg::IDX_PROGRAM_CNT:    rd_mux = state_ff.program_counter;
                brf_pkg::IDX_STACK_POINTER:  rd_mux = {4'h0, STACK_POINTER_O};
                brf_pkg::IDX_USER_STACK:     rd_mux = {4'h0, state_ff.user_stack_pointer};
                brf_pkg::IDX_IRQ_STACK:      rd_mux = {4'h0, state_ff.irq_stack_pointer};
                brf_pkg::IDX_STATIC_BASE:    rd_mux = {4'h0, state_ff.static_base};
                brf_pkg::IDX_PROC_FLAGS:     rd_mux = {9'h000, state_ff.flags};
                brf_pkg::IDX_DATA_ZERO_LOW:  rd_mux = {12'h000, cur_bank.word[0][7:0]};
                brf_pkg::IDX_DATA_ZERO_HIGH: rd_mux = {12'h000, cur_bank.word[0][15:8]};
                brf_pkg::IDX_DATA_ONE_LOW:   rd_mux = {12'h000, cur_bank.word[1][7:0]};
                brf_pkg::IDX_DATA_ONE_HIGH:  rd_mux = {12'h000, cur_bank.word[1][15:8]};
                default:                     rd_mux = 20'h00000;
            endcase
        end
    end

    // Next state: software writes first, hardware updates override them
    always_comb begin
        nxt_state = state_ff;
        if (REG_RD_I) begin
            nxt_state.rdata = rd_mux;
        end
        if (REG_WR_I) begin
            unique case (REG_ADDR_I)
                brf_pkg::IDX_VECTOR_BASE:
                    nxt_state.vector_table_base = REG_WDATA_I;
                brf_pkg::IDX_PROGRAM_CNT:
                    nxt_state.program_counter = REG_WDATA_I;
                brf_pkg::IDX_STACK_POINTER: begin
                    if (state_ff.flags.stack_sel) begin
                        nxt_state.user_stack_pointer = REG_WDATA_I[15:0];
                    end else begin
                        nxt_state.irq_stack_pointer = REG_WDATA_I[15:0];
                    end
                end
                brf_pkg::IDX_USER_STACK:
                    nxt_state.user_stack_pointer = REG_WDATA_I[15:0];
                brf_pkg::IDX_IRQ_STACK:
                    nxt_state.irq_stack_pointer = REG_WDATA_I[15:0];
                brf_pkg::IDX_STATIC_BASE:
                    nxt_state.static_base = REG_WDATA_I[15:0];
                brf_pkg::IDX_PROC_FLAGS:
                    nxt_state.flags = brf_pkg::brf_flags_t'(REG_WDATA_I[10:0]);
                default: begin
                end
            endcase
        end
        // ALU result beats a same-cycle software write of the flags
        if (ALU_UPD_I) begin
            nxt_state.flags.carry = ALU_CARRY_I;
            nxt_state.flags.zero  = calc_zero;
            nxt_state.flags.sign  = calc_sign;
            nxt_state.flags.ovf   = ALU_OVF_I;
        end
        // Acknowledge leaves handler on the irq stack with interrupts masked
        if (IRQ_ACK_I) begin
            nxt_state.flags.irq_en    = 1'b0;
            nxt_state.flags.stack_sel = 1'b0;
        end
        if (swi_to_irq_stack) begin
            nxt_state.flags.stack_sel = 1'b0;
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            nxt_state_reset: begin
                state_ff.vector_table_base  <= brf_pkg::RST_WIDE;
                state_ff.program_counter    <= brf_pkg::RST_WIDE;
                state_ff.user_stack_pointer <= brf_pkg::RST_WORD;
                state_ff.irq_stack_pointer  <= brf_pkg::RST_WORD;
                state_ff.static_base        <= brf_pkg::RST_WORD;
                state_ff.flags              <= brf_pkg::RST_FLAGS;
                state_ff.rdata              <= brf_pkg::RST_WIDE;
            end
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Operand views for the datapath
    assign LONG_DATA_PAIR_LOW_O  = {cur_bank.word[2], cur_bank.word[0]};
    assign LONG_DATA_PAIR_HIGH_O = {cur_bank.word[3], cur_bank.word[1]};
    assign LONG_ADDRESS_PAIR_O   = {cur_bank.word[5], cur_bank.word[4]};
    assign FRAME_BASE_O          = cur_bank.word[6];
    assign STATIC_BASE_O         = state_ff.static_base;
    assign VECTOR_TABLE_BASE_O   = state_ff.vector_table_base;
    assign PROGRAM_COUNTER_O     = state_ff.program_counter;
    assign STACK_POINTER_O       = state_ff.flags.stack_sel ? state_ff.user_stack_pointer
                                                            : state_ff.irq_stack_pointer;
    assign PROCESSOR_FLAGS_O     = state_ff.flags;
    assign REG_RDATA_O           = state_ff.rdata;

    // Checks on the design's own outputs
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    sequence s_ack;
        IRQ_ACK_I;
    endsequence

    sequence s_swi_low;
        SWI_I && (SWI_VEC_I <= brf_pkg::SWI_LAST_STACK_VEC);
    endsequence

    sequence s_flag_read;
        REG_RD_I && (REG_ADDR_I == brf_pkg::IDX_PROC_FLAGS) && !REG_WR_I;
    endsequence

    a_ack_clears_ie: assert property (s_ack |=> !PROCESSOR_FLAGS_O.irq_en)
        else $error("interrupt enable still set after acknowledge");

    a_ack_irq_stack: assert property (s_ack |=> !PROCESSOR_FLAGS_O.stack_sel)
        else $error("acknowledge did not move onto irq stack");

    a_swi_irq_stack: assert property (s_swi_low |=> !PROCESSOR_FLAGS_O.stack_sel)
        else $error("low software vector kept user stack");

    a_accept_level: assert property (IRQ_ACCEPT_O |-> PROCESSOR_FLAGS_O.irq_en
                                     && (IRQ_PRIO_I > PROCESSOR_FLAGS_O.processor_priority_level))
        else $error("interrupt accepted at or below priority level");

    a_masked_refuse: assert property (!PROCESSOR_FLAGS_O.irq_en |-> !IRQ_ACCEPT_O)
        else $error("interrupt accepted while masked");

    a_carry_capture: assert property (ALU_UPD_I |=> PROCESSOR_FLAGS_O.carry
                                      == $past(ALU_CARRY_I))
        else $error("carry flag missed alu carry");

    a_zero_word: assert property (ALU_UPD_I && !ALU_BYTE_I && ALU_RES_I == 16'h0000
                                  |=> PROCESSOR_FLAGS_O.zero)
        else $error("zero flag not set on zero result");

    a_sign_word: assert property (ALU_UPD_I && !ALU_BYTE_I
                                  |=> PROCESSOR_FLAGS_O.sign == $past(ALU_RES_I[15]))
        else $error("sign flag does not follow result");

    a_flag_readback: assert property (s_flag_read |=> REG_RDATA_O
                                      == {9'h000, $past(PROCESSOR_FLAGS_O)})
        else $error("flag read returned wrong word");

    a_bank_pair: assert property (LONG_DATA_PAIR_LOW_O[15:0]
                                  == (PROCESSOR_FLAGS_O.bank_sel ? bank_regs[1].word[0]
                                                                 : bank_regs[0].word[0]))
        else $error("operand not from selected bank");

endmodule : brf_regfile

`default_nettype wire

//--- tb/cpu_banked_register_file_tb_top.sv
// Self-checking bench of the banked register file: register port, banks, flags, interrupts.
// Assumes the brf_pkg package is compiled first; drives every port of the core itself.
`default_nettype none

module cpu_banked_register_file_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                CLK_I = 1'b0;
    logic                RST_B_I = 1'b0;
    logic [4:0]          REG_ADDR_I = 5'h00;
    logic [19:0]         REG_WDATA_I = 20'h00000;
    logic                REG_WR_I = 1'b0, REG_RD_I = 1'b0, ALU_UPD_I = 1'b0, ALU_BYTE_I = 1'b0;
    logic [15:0]         ALU_RES_I = 16'h0000;
    logic                ALU_CARRY_I = 1'b0, ALU_OVF_I = 1'b0, IRQ_REQ_I = 1'b0;
    logic [2:0]          IRQ_PRIO_I = 3'h0;
    logic                IRQ_ACK_I = 1'b0, SWI_I = 1'b0, IRQ_ACCEPT_O;
    logic [5:0]          SWI_VEC_I = 6'h00;
    logic [19:0]         REG_RDATA_O, VECTOR_TABLE_BASE_O, PROGRAM_COUNTER_O;
    logic [31:0]         LONG_DATA_PAIR_LOW_O, LONG_DATA_PAIR_HIGH_O, LONG_ADDRESS_PAIR_O;
    logic [15:0]         FRAME_BASE_O, STATIC_BASE_O, STACK_POINTER_O;
    brf_pkg::brf_flags_t PROCESSOR_FLAGS_O;

    // Reference state kept by the bench
    logic [15:0]         mb [2][7];
    logic [19:0]         mvb = 20'h0, mpc = 20'h0;
    logic [15:0]         musp = 16'h0, misp = 16'h0, msb = 16'h0;
    brf_pkg::brf_flags_t mf = brf_pkg::brf_flags_t'(11'h000);
    logic [31:0]         seed = 32'h39974275, r, d;
    int                  miscompares = 0, samples_checked = 0, n, p;

    brf_regfile dut (.*);

    // Free-running clock, 10 ns period
    always #5 CLK_I = ~CLK_I;

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction : rnd

    function automatic logic [19:0] mrd(input logic [4:0] a);
        if (a < 5'd7) return {4'h0, mb[mf.bank_sel][a[2:0]]};
        case (a)
            5'd7: return mvb;
            5'd8: return mpc;
            5'd9: return {4'h0, mf.stack_sel ? musp : misp};
            5'd10: return {4'h0, musp};
            5'd11: return {4'h0, misp};
            5'd12: return {4'h0, msb};
            5'd13: return {9'h0, mf};
            5'd14: return {12'h0, mb[mf.bank_sel][0][7:0]};
            5'd15: return {12'h0, mb[mf.bank_sel][0][15:8]};
            5'd16: return {12'h0, mb[mf.bank_sel][1][7:0]};
            5'd17: return {12'h0, mb[mf.bank_sel][1][15:8]};
            default: return 20'h00000;
        endcase
    endfunction : mrd

    // Writes land in the bank chosen before the write
    task automatic mwr(input logic [4:0] a, input logic [19:0] v);
        logic b;
        b = mf.bank_sel;
        if (a < 5'd7) mb[b][a[2:0]] = v[15:0];
        else if (a == 5'd7) mvb = v;
        else if (a == 5'd8) mpc = v;
        else if (a == 5'd9 && mf.stack_sel) musp = v[15:0];
        else if (a == 5'd9 || a == 5'd11) misp = v[15:0];
        else if (a == 5'd10) musp = v[15:0];
        else if (a == 5'd12) msb = v[15:0];
        else if (a == 5'd13) mf = brf_pkg::brf_flags_t'(v[10:0]);
        else if (a == 5'd14) mb[b][0][7:0] = v[7:0];
        else if (a == 5'd15) mb[b][0][15:8] = v[7:0];
        else if (a == 5'd16) mb[b][1][7:0] = v[7:0];
        else if (a == 5'd17) mb[b][1][15:8] = v[7:0];
    endtask : mwr

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [4:0] a, input logic [19:0] v);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_WDATA_I <= v;
        REG_WR_I <= 1'b1;
        @(posedge CLK_I);
        REG_WR_I <= 1'b0;
        mwr(a, v);
        #1;
    endtask : wr

    // Read data appear in the cycle after the strobe and hold until the next read strobe
    task automatic rd_chk(input logic [4:0] a);
        @(posedge CLK_I);
        REG_ADDR_I <= a;
        REG_RD_I <= 1'b1;
        @(posedge CLK_I);
        REG_RD_I <= 1'b0;
        #1;
        check(32'(REG_RDATA_O), 32'(mrd(a)));
    endtask : rd_chk

    task automatic check_outs();
        logic b;
        b = mf.bank_sel;
        check(LONG_DATA_PAIR_LOW_O, {mb[b][2], mb[b][0]});
        check(LONG_DATA_PAIR_HIGH_O, {mb[b][3], mb[b][1]});
        check(LONG_ADDRESS_PAIR_O, {mb[b][5], mb[b][4]});
        check(32'(FRAME_BASE_O), 32'(mb[b][6]));
        check(32'(STATIC_BASE_O), 32'(msb));
        check(32'(VECTOR_TABLE_BASE_O), 32'(mvb));
        check(32'(PROGRAM_COUNTER_O), 32'(mpc));
        check(32'(STACK_POINTER_O), 32'(mf.stack_sel ? musp : misp));
        check(32'(PROCESSOR_FLAGS_O), 32'(mf));
    endtask : check_outs

    // One ALU update; zero and sign judged on the byte in byte mode
    task automatic alu(input logic [15:0] res, input logic byt, input logic c, input logic o);
        @(posedge CLK_I);
        {ALU_UPD_I, ALU_RES_I, ALU_BYTE_I, ALU_CARRY_I, ALU_OVF_I} <= {1'b1, res, byt, c, o};
        @(posedge CLK_I);
        ALU_UPD_I <= 1'b0;
        #1;
        check(32'(PROCESSOR_FLAGS_O.carry), 32'(c));
        check(32'(PROCESSOR_FLAGS_O.zero), 32'(byt ? res[7:0] == 8'h0 : res == 16'h0));
        check(32'(PROCESSOR_FLAGS_O.sign), 32'(byt ? res[7] : res[15]));
        check(32'(PROCESSOR_FLAGS_O.ovf), 32'(o));
        {mf.carry, mf.ovf} = {c, o};
        mf.zero = byt ? (res[7:0] == 8'h0) : (res == 16'h0);
        mf.sign = byt ? res[7] : res[15];
    endtask : alu

    // Acknowledge or software interrupt pulse, then compare flags and stack
    task automatic event_pulse(input logic ack, input logic [5:0] vec);
        @(posedge CLK_I);
        {IRQ_ACK_I, SWI_I, SWI_VEC_I} <= {ack, ~ack, vec};
        @(posedge CLK_I);
        {IRQ_ACK_I, SWI_I} <= 2'b00;
        if (ack) mf.irq_en = 1'b0;
        if (ack || vec <= 6'd31) mf.stack_sel = 1'b0;
        #1;
        check(32'(PROCESSOR_FLAGS_O.stack_sel), 32'(mf.stack_sel));
        check_outs();
    endtask : event_pulse

    // Hang guard, well beyond the expected run length
    initial begin
        repeat (40000) @(posedge CLK_I);
        miscompares++;
        end_sim();
    end

    initial begin
        for (n = 0; n < 14; n++) {mb[0][n % 7], mb[1][n % 7]} = 32'h0;
        repeat (8) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        #1;
        check_outs();
        for (n = 0; n < 32; n++) rd_chk(5'(n));
        // Software vector boundary with the user stack and interrupts on
        for (n = 0; n < 4; n++) begin
            wr(5'd13, 20'h000c0);
            event_pulse(1'b0, n[0] ? 6'(31 + n / 2) : 6'(63 * (n / 2)));
        end
        wr(5'd13, 20'h000c0);
        event_pulse(1'b1, 6'h00);
        alu(16'h0000, 1'b0, 1'b1, 1'b0);
        alu(16'hff80, 1'b1, 1'b0, 1'b1);
        alu(16'h8000, 1'b1, 1'b1, 1'b1);
        for (n = 0; n < 400; n++) begin
            r = rnd();
            d = rnd();
            // Debug and reserved flag bits held at zero by software
            if (r[4:0] == 5'd13) d[19:0] = d[19:0] & 20'h007fd;
            wr(r[4:0], d[19:0]);
            check_outs();
            rd_chk(r[9:5]);
            case (r[12:10])
                3'd0: alu(d[31:16], r[13], r[14], r[15]);
                3'd1: event_pulse(1'b1, 6'h00);
                3'd2: event_pulse(1'b0, d[25:20]);
                default: begin
                    for (p = 0; p < 8; p++) begin
                        @(posedge CLK_I);
                        IRQ_REQ_I <= r[16 + p];
                        IRQ_PRIO_I <= 3'(p);
                        @(posedge CLK_I);
                        #1;
                        check(32'(IRQ_ACCEPT_O), 32'(r[16 + p] && mf.irq_en && p > mf.processor_priority_level));
                        // Top priority still loses to a level of seven
                        if (p == 7) check(32'(IRQ_ACCEPT_O),
                                          32'(r[23] && mf.irq_en && mf.processor_priority_level != 3'h7));
                    end
                end
            endcase
        end
        end_sim();
    end

endmodule : cpu_banked_register_file_tb_top

`default_nettype wire
